//--- test/bpao_chk_props.sv
// Checker of port relations for the blink phase and alert control
`timescale 1ns/1ns
module bpao_chk_props
	import bpao_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [15:0] port_pin_in,
	input wire logic [15:0] port_pin_out,
	input wire logic [15:0] port_pin_oe_b,
	input wire logic        phase_toggle_pin,
	input wire logic        alert_or_spare_pin_out,
	input wire logic        alert_or_spare_pin_oe_b,
	input wire logic [67:0] intensity_sel
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Open-drain lines only ever sink
	AST_PORT_LOW: assert property (port_pin_out == 16'h0000)
		else $error("port data not low");
	AST_ALERT_LOW: assert property (alert_or_spare_pin_out == 1'b0)
		else $error("alert data not low");
	// Live toggle level after three steady samples
	AST_LIVE_PIN: assert property (($stable(phase_toggle_pin))[*3] ##0
		(reg_rd && reg_addr == OFS_SETUP) |=> reg_rdata[6] == $past(phase_toggle_pin))
		else $error("live toggle bit wrong");
	// Stored pattern returned
	AST_PAT_READ: assert property (reg_wr && reg_addr == OFS_PH0_LO ##2
		reg_rd && reg_addr == OFS_PH0_LO |=> reg_rdata == $past(reg_wdata, 3))
		else $error("pattern readback wrong");
	// Input lines are left floating
	AST_DIR_FLOAT: assert property (reg_wr && reg_addr == OFS_DIR_LO && reg_wdata == 8'hff
		##1 !(reg_wr && reg_addr == OFS_DIR_LO) |=> port_pin_oe_b[7:0] == 8'hff)
		else $error("input port driven");
	AST_SHARED: assert property (reg_wr && reg_addr == OFS_MASTER ##2 (reg_wr
		&& reg_addr == OFS_SETUP && reg_wdata[2]) ##1 !reg_wr
		|=> intensity_sel[7:4] == $past(reg_wdata[3:0], 4))
		else $error("shared level not applied");
	AST_ALERT_LVL: assert property (reg_wr && reg_addr == OFS_MASTER ##1 !reg_wr
		|=> intensity_sel[67:64] == $past(reg_wdata[3:0], 2))
		else $error("alert level wrong");
	AST_SPARE: assert property (reg_wr && reg_addr == OFS_SETUP && reg_wdata[3:0] == 4'h4
		##1 !reg_wr |=> alert_or_spare_pin_oe_b == $past(reg_wdata[4], 2))
		else $error("spare level wrong");
endmodule

//--- test/bpao_host_model.sv
// Host side of the register strobe port
`timescale 1ns/1ns
module bpao_host_model (
	input  wire logic       core_clk,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	// Idle strobes from time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read strobe, data taken one edge after the strobe drops
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask
	// Slow host: idle cycles
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the blink phase and alert control
`timescale 1ns/1ns
module tb_top;
	import bpao_pkg::*;
	logic        core_clk, rst_b, tgl, ra_wr, ra_rd;
	logic [7:0]  ra, wd, rdat, v, e;
	logic [15:0] ext, pin_oe_b, pout;
	logic        al_oe_b, aout;
	logic [67:0] lvl;
	int          fail_count, checks;
	// Open-drain wire with pull-ups and external drivers
	wire  [15:0] pins = ext & pin_oe_b;
	bpao_host_model host(.core_clk(core_clk), .reg_addr(ra), .reg_wdata(wd), .reg_wr(ra_wr),
		.reg_rd(ra_rd), .reg_rdata(rdat));
	bpao_blink_ctrl dut(.core_clk(core_clk), .rst_b(rst_b), .reg_addr(ra), .reg_wdata(wd),
		.reg_wr(ra_wr), .reg_rd(ra_rd), .reg_rdata(rdat), .port_pin_in(pins),
		.port_pin_out(pout), .port_pin_oe_b(pin_oe_b), .phase_toggle_pin(tgl),
		.alert_or_spare_pin_out(aout), .alert_or_spare_pin_oe_b(al_oe_b), .intensity_sel(lvl));
	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic stop_test;
		if (fail_count == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Clock of 50 ns
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		stop_test;
	end
	initial begin
		rst_b = 1'b0;
		tgl = 1'b0;
		ext = 16'hffff;
		host.idle(2);
		rst_b <= 1'b1;
		host.idle(3);
		host.rd(OFS_MASTER, v);
		chk("master reset", v, RST_MASTER);
		host.rd(OFS_SETUP, v);
		chk("setup reset", v, {2'b00, RST_SETUP});
		chk("no start alert", {7'h00, al_oe_b}, 8'h01);
		host.rd(OFS_PH1_LO, v);
		chk("phase1 reset", v, RST_PH1);
		host.wr(OFS_DIR_LO, 8'h00);
		host.wr(OFS_PH0_LO, 8'h5a);
		host.rd(OFS_PH0_LO, v);
		chk("phase0 readback", v, 8'h5a);
		host.wr(OFS_PH1_LO, 8'ha5);
		host.wr(OFS_PH1_HI, 8'hff);
		// Every enable, invert and pin combination
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			tgl <= i[0];
			host.wr(OFS_SETUP, 8'h14 | {6'h00, i[1], i[2]});
			host.idle(5);
			e = (i[2] & (i[1] ^ i[0])) ? 8'ha5 : 8'h5a;
			chk("port pattern", pin_oe_b[7:0], e);
			chk("spare pin", {7'h00, al_oe_b}, {7'h00, e == 8'h5a});
			host.rd(OFS_SETUP, v);
			chk("setup read", v, {1'b0, i[0], 6'h14 | {4'h0, i[1], i[2]}});
		end
		host.rd(8'h20, v);
		chk("unmapped read", v, RD_UNMAPPED);
		// Input change on an input port
		host.wr(OFS_SETUP, 8'h1c);
		@(posedge core_clk);
		ext[8] <= 1'b0;
		host.idle(5);
		chk("alert low", {7'h00, al_oe_b}, 8'h00);
		host.rd(OFS_SETUP, v);
		chk("change set", {7'h00, v[7]}, 8'h01);
		ext[8] <= 1'b1;
		host.idle(5);
		chk("alert released", {7'h00, al_oe_b}, 8'h01);
		ext[8] <= 1'b0;
		host.idle(5);
		host.rd(OFS_IN_HI, v);
		chk("input read", v, 8'hfe);
		host.rd(OFS_SETUP, v);
		chk("change cleared", {7'h00, v[7]}, 8'h00);
		// Per-port and shared intensity
		host.wr(OFS_INT_LO, 8'h3c);
		host.wr(OFS_MASTER, 8'h07);
		host.wr(OFS_SETUP, 8'h10);
		host.idle(2);
		chk("own level", lvl[7:0], 8'h3c);
		chk("alert level", {4'h0, lvl[67:64]}, 8'h07);
		host.wr(OFS_MASTER, 8'h06);
		host.wr(OFS_SETUP, 8'h14);
		host.idle(2);
		chk("shared level", lvl[7:0], 8'h66);
		chk("shared alert level", {4'h0, lvl[67:64]}, 8'h06);
		host.wr(OFS_DIR_LO, 8'hff);
		host.idle(2);
		chk("inputs float", pin_oe_b[7:0], 8'hff);
		chk("open drain data", pout[7:0] | pout[15:8] | {7'h00, aout}, 8'h00);
		// Low byte turned to inputs, then resampled by its input read
		ext[7:0] <= 8'h96;
		host.idle(3);
		host.rd(OFS_SETUP, v);
		chk("low byte change", {7'h00, v[7]}, 8'h01);
		host.rd(OFS_IN_LO, v);
		chk("low input read", v, 8'h96);
		host.rd(OFS_SETUP, v);
		chk("low change cleared", {7'h00, v[7]}, 8'h00);
		stop_test;
	end
endmodule
bind bpao_blink_ctrl bpao_chk_props chk(.core_clk(core_clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
	.port_pin_oe_b(port_pin_oe_b), .phase_toggle_pin(phase_toggle_pin),
	.alert_or_spare_pin_out(alert_or_spare_pin_out),
	.alert_or_spare_pin_oe_b(alert_or_spare_pin_oe_b), .intensity_sel(intensity_sel));

//--- verilog/bpao_blink_ctrl.sv
// Register file, blink phase selection, port and alert pin control
`timescale 1ns/1ns
module bpao_blink_ctrl
	import bpao_pkg::*;
(
	input  wire logic                            core_clk,
	input  wire logic                            rst_b,
	input  wire logic [7:0]                      reg_addr,
	input  wire logic [7:0]                      reg_wdata,
	input  wire logic                            reg_wr,
	input  wire logic                            reg_rd,
	output logic      [7:0]                      reg_rdata,
	input  wire logic [bpao_pkg::PORT_N-1:0]     port_pin_in,
	output logic      [bpao_pkg::PORT_N-1:0]     port_pin_out,
	output logic      [bpao_pkg::PORT_N-1:0]     port_pin_oe_b,
	input  wire logic                            phase_toggle_pin,
	output logic                                 alert_or_spare_pin_out,
	output logic                                 alert_or_spare_pin_oe_b,
	output logic      [bpao_pkg::LEVEL_N*bpao_pkg::LEVEL_W-1:0] intensity_sel
);
	import bpao_pkg::*;

	bpao_chg_if chg ();

	// Pin synchronisers
	logic [PORT_N-1:0] port_meta;
	logic [PORT_N-1:0] port_sync;
	logic              tog_meta;
	logic              tog_sync;

	// Register state
	logic [PORT_N-1:0] ph0;
	logic [PORT_N-1:0] ph1;
	logic [PORT_N-1:0] dir_in;
	logic [7:0]        master;
	logic [5:0]        setup;
	logic [7:0]        inten [INTEN_N];
	logic [7:0]        rdata;
	logic [PORT_N-1:0] next_ph0;
	logic [PORT_N-1:0] next_ph1;
	logic [PORT_N-1:0] next_dir_in;
	logic [7:0]        next_master;
	logic [5:0]        next_setup;
	logic [7:0]        next_inten [INTEN_N];
	logic [7:0]        next_rdata;

	// Pin driver state
	logic [PORT_N-1:0] port_oe_q;
	logic              alert_oe_q;
	logic [LEVEL_N*LEVEL_W-1:0] level_q;
	logic [PORT_N-1:0] next_port_oe;
	logic              next_alert_oe;
	logic [LEVEL_N*LEVEL_W-1:0] next_level;

	logic              phase;
	logic [PORT_N-1:0] pattern;
	logic              spare_level;
	logic              idx_hit;
	logic [2:0]        idx;

	bpao_change_detect u_detect (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.chg      (chg)
	);

	// Two-stage synchronisers on pins
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			port_meta <= '0;
			port_sync <= '0;
			tog_meta  <= 1'b0;
			tog_sync  <= 1'b0;
		end else begin
			port_meta <= port_pin_in;
			port_sync <= port_meta;
			tog_meta  <= phase_toggle_pin;
			tog_sync  <= tog_meta;
		end
	end

	// Detector hookup; reading an input byte or writing setup resamples
	assign chg.live        = port_sync;
	assign chg.is_input    = dir_in;
	assign chg.resample[0] = (reg_rd && reg_addr == OFS_IN_LO) ||
	                         (reg_wr && reg_addr == OFS_SETUP);
	assign chg.resample[1] = (reg_rd && reg_addr == OFS_IN_HI) ||
	                         (reg_wr && reg_addr == OFS_SETUP);

	// Intensity register index decode
	assign idx_hit = (reg_addr >= OFS_INT_LO) && (reg_addr <= OFS_INT_HI);
	assign idx     = 3'(reg_addr - OFS_INT_LO);

	// Register writes and read data
	always_comb begin
		next_ph0    = ph0;
		next_ph1    = ph1;
		next_dir_in = dir_in;
		next_master = master;
		next_setup  = setup;
		next_inten  = inten;
		next_rdata  = rdata;
		if (reg_wr) begin
			unique case (reg_addr)
				OFS_PH0_LO: next_ph0[7:0]   = reg_wdata;
				OFS_PH0_HI: next_ph0[15:8]  = reg_wdata;
				OFS_PH1_LO: next_ph1[7:0]   = reg_wdata;
				OFS_PH1_HI: next_ph1[15:8]  = reg_wdata;
				OFS_DIR_LO: next_dir_in[7:0]  = reg_wdata;
				OFS_DIR_HI: next_dir_in[15:8] = reg_wdata;
				OFS_MASTER: next_master = reg_wdata;
				OFS_SETUP:  next_setup  = reg_wdata[5:0] & SETUP_WR_MASK;
				default: begin
					if (idx_hit) begin
						next_inten[idx] = reg_wdata;
					end
				end
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_IN_LO:  next_rdata = port_sync[7:0];
				OFS_IN_HI:  next_rdata = port_sync[15:8];
				OFS_PH0_LO: next_rdata = ph0[7:0];
				OFS_PH0_HI: next_rdata = ph0[15:8];
				OFS_PH1_LO: next_rdata = ph1[7:0];
				OFS_PH1_HI: next_rdata = ph1[15:8];
				OFS_DIR_LO: next_rdata = dir_in[7:0];
				OFS_DIR_HI: next_rdata = dir_in[15:8];
				OFS_MASTER: next_rdata = master;
				OFS_SETUP:  next_rdata = {chg.changed, tog_sync, setup};
				default:    next_rdata = idx_hit ? inten[idx] : RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ph0    <= {RST_PH0, RST_PH0};
			ph1    <= {RST_PH1, RST_PH1};
			dir_in <= {RST_DIR, RST_DIR};
			master <= RST_MASTER;
			setup  <= RST_SETUP;
			inten  <= '{default: RST_INTEN};
			rdata  <= RD_UNMAPPED;
		end else begin
			ph0    <= next_ph0;
			ph1    <= next_ph1;
			dir_in <= next_dir_in;
			master <= next_master;
			setup  <= next_setup;
			inten  <= next_inten;
			rdata  <= next_rdata;
		end
	end

	// Phase selection and pattern choice
	assign phase   = setup[BIT_BLINK_EN] & (setup[BIT_PHASE_INV] ^ tog_sync);
	assign pattern = phase ? ph1 : ph0;

	// Spare level by blink phase
	assign spare_level = (setup[BIT_BLINK_EN] && phase) ? setup[BIT_SPARE_P1] :
	                     setup[BIT_SPARE_P0];

	// Drive enables: input ports or pattern 1 float, else drive low
	always_comb begin
		next_port_oe = dir_in | pattern;
		if (setup[BIT_ALERT_EN]) begin
			next_alert_oe = ~chg.changed;
		end else begin
			next_alert_oe = spare_level;
		end
	end

	// Intensity select per output port, alert pin uses master
	genvar p;
	generate
		for (p = 0; p < PORT_N; p++) begin : g_level
			assign next_level[p*LEVEL_W +: LEVEL_W] = setup[BIT_SHARED_LVL] ?
				master[LEVEL_W-1:0] : inten[p/2][(p%2)*LEVEL_W +: LEVEL_W];
		end
	endgenerate
	assign next_level[PORT_N*LEVEL_W +: LEVEL_W] = master[LEVEL_W-1:0];

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			port_oe_q  <= '1;
			alert_oe_q <= 1'b1;
			level_q    <= '0;
		end else begin
			port_oe_q  <= next_port_oe;
			alert_oe_q <= next_alert_oe;
			level_q    <= next_level;
		end
	end

	// Open-drain outputs: data always low, enable active low
	assign port_pin_out            = '0;
	assign port_pin_oe_b           = port_oe_q;
	assign alert_or_spare_pin_out  = 1'b0;
	assign alert_or_spare_pin_oe_b = alert_oe_q;
	assign intensity_sel           = level_q;
	assign reg_rdata               = rdata;
endmodule

//--- verilog/bpao_change_detect.sv
// Input change detector: per-bit snapshot and compare
`timescale 1ns/1ns
module bpao_change_detect
	import bpao_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst_b,
	bpao_chg_if.det   chg
);
	logic [PORT_N-1:0] snap;
	logic [PORT_N-1:0] next_snap;
	logic [1:0]        prime_cnt;
	logic [1:0]        next_prime_cnt;
	logic              primed;

	// Snapshot follows the synced pins until primed, then reloads on byte resample
	genvar i;
	generate
		for (i = 0; i < PORT_N; i++) begin : g_bit
			assign next_snap[i] = (!primed || chg.resample[i/8]) ? chg.live[i] : snap[i];
		end
	endgenerate
	// Priming waits out both synchroniser stages, so reset gives no false change
	assign primed         = &prime_cnt;
	assign next_prime_cnt = primed ? prime_cnt : prime_cnt + 2'h1;

	// Registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			snap      <= '0;
			prime_cnt <= '0;
		end else begin
			snap      <= next_snap;
			prime_cnt <= next_prime_cnt;
		end
	end

	// Change raised while any input differs; clears when it returns
	assign chg.snapshot = snap;
	assign chg.changed  = primed && |((chg.live ^ snap) & chg.is_input);
endmodule

//--- verilog/bpao_chg_if.sv
// Interface between the control block and the input change detector
`timescale 1ns/1ns
interface bpao_chg_if;
	logic [15:0] live;
	logic [15:0] is_input;
	logic [1:0]  resample;
	logic [15:0] snapshot;
	logic        changed;
	modport ctrl (output live, output is_input, output resample, input snapshot, input changed);
	modport det  (input live, input is_input, input resample, output snapshot, output changed);
endinterface

//--- verilog/bpao_pkg.sv
// Package of offsets, fields, reset values and widths for the blink phase and alert control
package bpao_pkg;
	// Port geometry
	localparam int          PORT_N      = 16;
	localparam int          LEVEL_W     = 4;
	localparam int          LEVEL_N     = 17;
	localparam int          INTEN_N     = 8;
	// Register offsets
	localparam logic [7:0]  OFS_IN_LO   = 8'h00;
	localparam logic [7:0]  OFS_IN_HI   = 8'h01;
	localparam logic [7:0]  OFS_PH0_LO  = 8'h02;
	localparam logic [7:0]  OFS_PH0_HI  = 8'h03;
	localparam logic [7:0]  OFS_DIR_LO  = 8'h06;
	localparam logic [7:0]  OFS_DIR_HI  = 8'h07;
	localparam logic [7:0]  OFS_PH1_LO  = 8'h0a;
	localparam logic [7:0]  OFS_PH1_HI  = 8'h0b;
	localparam logic [7:0]  OFS_MASTER  = 8'h0e;
	localparam logic [7:0]  OFS_SETUP   = 8'h0f;
	localparam logic [7:0]  OFS_INT_LO  = 8'h10;
	localparam logic [7:0]  OFS_INT_HI  = 8'h17;
	// Fields of device_setup_and_status
	localparam int          BIT_BLINK_EN   = 0;
	localparam int          BIT_PHASE_INV  = 1;
	localparam int          BIT_SHARED_LVL = 2;
	localparam int          BIT_ALERT_EN   = 3;
	localparam int          BIT_SPARE_P0   = 4;
	localparam int          BIT_SPARE_P1   = 5;
	localparam int          BIT_PIN_LIVE   = 6;
	localparam int          BIT_CHANGED    = 7;
	localparam logic [5:0]  SETUP_WR_MASK  = 6'h3f;
	// Reset values
	localparam logic [7:0]  RST_PH0     = 8'hff;
	localparam logic [7:0]  RST_PH1     = 8'hff;
	localparam logic [7:0]  RST_DIR     = 8'hff;
	localparam logic [7:0]  RST_MASTER  = 8'h0f;
	localparam logic [5:0]  RST_SETUP   = 6'h0c;
	localparam logic [7:0]  RST_INTEN   = 8'hff;
	localparam logic [7:0]  RD_UNMAPPED = 8'h00;
endpackage
